// ===== logic/gpt_pkg.sv
// constants shared by the quad timer block and its channel module
`default_nettype none
package gpt_pkg;
  // block shape
  localparam int NUM_TIMERS = 4;
  localparam int CNT_W      = 32;
  localparam int ADDR_W     = 8;
  localparam int FRAC_W     = 8;
  // global register byte offsets
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h00;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h04;
  localparam logic [7:0] OFF_UNIT_INT  = 8'h08;
  localparam logic [7:0] OFF_UNIT_FRAC = 8'h0C;
  // per timer window: base + index * stride
  localparam logic [7:0] OFF_TMR_BASE  = 8'h10;
  localparam logic [7:0] TMR_STRIDE    = 8'h10;
  localparam logic [3:0] OFF_CTRL      = 4'h0;
  localparam logic [3:0] OFF_LOAD      = 4'h4;
  localparam logic [3:0] OFF_COUNT     = 4'h8;
  // control field positions
  localparam int CTRL_EN_BIT       = 0;
  localparam int CTRL_PERIODIC_BIT = 1;
  localparam int CTRL_TIMER_BIT    = 2;
  localparam int CTRL_COARSE_BIT   = 3;
  localparam int CTRL_W            = 4;
  // timing: clock period and fine unit in ns
  localparam int CLK_PERIOD_NS = 100;
  localparam int FINE_UNIT_NS  = 1000;
  localparam logic [7:0] UNIT_INT_RST  = 8'(FINE_UNIT_NS / CLK_PERIOD_NS);
  localparam logic [7:0] UNIT_FRAC_RST = 8'h00;
  // coarse unit measured in fine units
  localparam int COARSE_RATIO = 256;
  localparam logic [7:0] COARSE_LAST = 8'(COARSE_RATIO - 1);
  // reset values
  localparam logic [31:0] LOAD_RST = 32'h0000_0000;
  localparam logic [3:0]  MASK_RST = 4'h0;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== logic/gpt_channel.sv
// one down-counting timer channel with unit prescaler and timeout pulse
`default_nettype none
`timescale 1ns/100ps
module gpt_channel (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // configuration
  input  wire logic        enable,
  input  wire logic        periodic,
  input  wire logic        timer_mode,
  input  wire logic        coarse,
  input  wire logic [31:0] load_val,
  // unit sources
  input  wire logic        us_tick,
  input  wire logic        evt_tick,
  // state
  output logic [31:0]      count_q,
  output logic             timeout_q
);
  logic [31:0] count_d;   // next count
  logic        timeout_d; // next timeout pulse
  logic        run_q;     // enable seen last cycle
  logic [7:0]  pre_q;     // coarse prescaler
  logic [7:0]  pre_d;
  logic        unit;      // one time unit or event elapsed

  ////////////////////////////////////////////////////////////////////////
  // unit selection and countdown
  always_comb begin
    // counter mode counts events, timer mode counts 1 us or 256 us units
    if (!timer_mode) begin
      unit = evt_tick;
    end else if (coarse) begin
      unit = us_tick && (pre_q == gpt_pkg::COARSE_LAST);
    end else begin
      unit = us_tick;
    end
    count_d   = count_q;
    timeout_d = 1'b0;
    pre_d     = pre_q;
    if (enable && !run_q) begin
      // start: load programmed count, restart prescaler so the first coarse unit is whole
      count_d = load_val;
      pre_d   = 8'h00;
    end else if (enable) begin
      if (us_tick) begin
        pre_d = pre_q + 8'h01;
      end
      if (unit) begin
        if (count_q <= 32'h0000_0001) begin
          // zero load behaves as one unit
          timeout_d = 1'b1;
          count_d   = periodic ? load_val : 32'h0000_0000;
        end else begin
          count_d = count_q - 32'h0000_0001;
        end
      end
    end
  end

  // registers only; a stopped channel holds its count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q   <= 32'h0000_0000;
      timeout_q <= 1'b0;
      pre_q     <= 8'h00;
      run_q     <= 1'b0;
    end else begin
      count_q   <= count_d;
      timeout_q <= timeout_d;
      pre_q     <= pre_d;
      run_q     <= enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  hold_stopped_a : assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |=> $stable(count_q)) else $error("stopped timer changed count");
  fine_step_a : assert property (@(posedge aclk) disable iff (!aresetn)
    run_q && enable && timer_mode && !coarse && us_tick && count_q > 32'h1
    |=> count_q == $past(count_q) - 32'h1) else $error("fine unit did not decrement");
  coarse_wait_a : assert property (@(posedge aclk) disable iff (!aresetn)
    run_q && enable && timer_mode && coarse && pre_q != gpt_pkg::COARSE_LAST
    |=> $stable(count_q)) else $error("coarse count moved early");
  event_step_a : assert property (@(posedge aclk) disable iff (!aresetn)
    run_q && enable && !timer_mode && evt_tick && count_q > 32'h1
    |=> count_q == $past(count_q) - 32'h1) else $error("event did not decrement");
  reload_value_a : assert property (@(posedge aclk) disable iff (!aresetn)
    timeout_q |-> count_q == ($past(periodic) ? $past(load_val) : 32'h0))
    else $error("wrong count after timeout");
endmodule
`default_nettype wire

// ===== logic/gpt_top.sv
// quad general purpose timer with axi4-lite register slave and interrupt
// Notes on behaviour
// - four independent timers, 32-bit counts each
// - per-timer enable starts or stops one timer
// - each timer counts events or time units
// - fine setting counts one microsecond units
// - coarse setting counts 256 microsecond units
// - unit derivation uses integer and fractional divisor
// - one-shot or periodic selectable per timer
// - per-timer interrupt option on timeout
//
// Our own choices: register access over AXI4-Lite and the address map.
`default_nettype none
`timescale 1ns/100ps
module gpt_top #(
  parameter int NUM_TIMERS = gpt_pkg::NUM_TIMERS
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [7:0]        awaddr,
  // axi4-lite write data
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  // axi4-lite write response
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // axi4-lite read address
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [7:0]        araddr,
  // axi4-lite read data
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // event pins for counter mode, asynchronous
  input  wire logic [NUM_TIMERS-1:0] evt_in,
  // interrupt level
  output logic                   irq
);
  initial begin
    if (NUM_TIMERS < 1 || NUM_TIMERS > 4) begin
      $error("NUM_TIMERS must be 1 to 4");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // merge write data into a word under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // timer index of a timer-window address, or NUM_TIMERS when outside
  function automatic int tmr_idx(input logic [7:0] a);
    int k;
    k = NUM_TIMERS;
    if (a >= gpt_pkg::OFF_TMR_BASE) begin
      k = int'((a - gpt_pkg::OFF_TMR_BASE) >> 4);
    end
    if (k > NUM_TIMERS) k = NUM_TIMERS;
    return k;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state declarations
  logic              aw_got_q, aw_got_d;   // address captured
  logic              w_got_q, w_got_d;     // data captured
  logic [7:0]        waddr_q, waddr_d;     // captured address
  logic [31:0]       wdat_q, wdat_d;       // captured data
  logic [3:0]        wbe_q, wbe_d;         // captured strobes
  logic              awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]        bresp_d, rresp_d;
  logic [31:0]       rdata_d;
  logic              wr_en;                // register write this cycle
  logic              irq_d;
  logic [NUM_TIMERS-1:0] stat_q, stat_d;   // sticky timeout flags
  logic [NUM_TIMERS-1:0] mask_q, mask_d;   // interrupt option per timer
  logic [7:0]        uint_q, uint_d;       // clocks per us, integer part
  logic [7:0]        ufrac_q, ufrac_d;     // clocks per us, /256 part
  logic [3:0]        ctrl_q [NUM_TIMERS];  // per-timer control
  logic [3:0]        ctrl_d [NUM_TIMERS];
  logic [31:0]       load_q [NUM_TIMERS];  // programmed counts
  logic [31:0]       load_d [NUM_TIMERS];
  logic [31:0]       count  [NUM_TIMERS];  // live counts
  logic [NUM_TIMERS-1:0] tmo;              // timeout pulses
  logic [7:0]        div_q, div_d;         // us divider count
  logic [7:0]        acc_q, acc_d;         // fraction accumulator
  logic              extra_q, extra_d;     // stretch next unit by one clock
  logic              tick_q, tick_d;       // one-cycle 1 us enable
  logic [NUM_TIMERS-1:0] es1_q, es2_q, es3_q; // event synchroniser and edge

  ////////////////////////////////////////////////////////////////////////
  // write channel handling
  always_comb begin
    aw_got_d  = aw_got_q;
    w_got_d   = w_got_q;
    waddr_d   = waddr_q;
    wdat_d    = wdat_q;
    wbe_d     = wbe_q;
    awready_d = awready;
    wready_d  = wready;
    bvalid_d  = bvalid;
    bresp_d   = bresp;
    wr_en     = 1'b0;
    // address and data are taken in either order
    if (awvalid && awready) begin
      aw_got_d  = 1'b1;
      waddr_d   = awaddr;
      awready_d = 1'b0;
    end
    if (wvalid && wready) begin
      w_got_d  = 1'b1;
      wdat_d   = wdata;
      wbe_d    = wstrb;
      wready_d = 1'b0;
    end
    if (aw_got_q && w_got_q) begin
      wr_en    = 1'b1;
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = (waddr_q[1:0] == 2'b00 && (waddr_q < gpt_pkg::OFF_TMR_BASE
                  || (tmr_idx(waddr_q) < NUM_TIMERS && waddr_q[3:0] != gpt_pkg::OFF_COUNT
                      && waddr_q[3:2] != 2'b11)))
                 ? gpt_pkg::RESP_OKAY : gpt_pkg::RESP_SLVERR;
    end
    // readies return only after the response is taken: one write at a time
    if (bvalid && bready) begin
      bvalid_d  = 1'b0;
      awready_d = 1'b1;
      wready_d  = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file next state
  always_comb begin
    int k;
    k       = tmr_idx(waddr_q);
    // hardware set wins over a write-one clear in the same cycle
    stat_d  = (stat_q & ~((wr_en && waddr_q == gpt_pkg::OFF_IRQ_STAT && wbe_q[0])
                          ? wdat_q[NUM_TIMERS-1:0] : '0)) | tmo;
    mask_d  = mask_q;
    uint_d  = uint_q;
    ufrac_d = ufrac_q;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      ctrl_d[i] = ctrl_q[i];
      load_d[i] = load_q[i];
      // one-shot timeout stops the timer
      if (tmo[i] && !ctrl_q[i][gpt_pkg::CTRL_PERIODIC_BIT]) begin
        ctrl_d[i][gpt_pkg::CTRL_EN_BIT] = 1'b0;
      end
    end
    if (wr_en) begin
      if (waddr_q == gpt_pkg::OFF_IRQ_MASK && wbe_q[0]) begin
        mask_d = wdat_q[NUM_TIMERS-1:0];
      end
      if (waddr_q == gpt_pkg::OFF_UNIT_INT && wbe_q[0]) begin
        uint_d = wdat_q[7:0];
      end
      if (waddr_q == gpt_pkg::OFF_UNIT_FRAC && wbe_q[0]) begin
        ufrac_d = wdat_q[7:0];
      end
      if (k < NUM_TIMERS) begin
        // a software write to control wins over a same-cycle one-shot stop
        if (waddr_q[3:0] == gpt_pkg::OFF_CTRL && wbe_q[0]) begin
          ctrl_d[k] = wdat_q[3:0];
        end
        if (waddr_q[3:0] == gpt_pkg::OFF_LOAD) begin
          load_d[k] = merge(load_q[k], wdat_q, wbe_q);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read channel; answers one cycle after the address is taken
  always_comb begin
    int k;
    k         = tmr_idx(araddr);
    arready_d = arready;
    rvalid_d  = rvalid;
    rdata_d   = rdata;
    rresp_d   = rresp;
    if (arvalid && arready) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = gpt_pkg::RESP_OKAY;
      rdata_d   = 32'h0000_0000;
      if (araddr[1:0] != 2'b00) begin
        rresp_d = gpt_pkg::RESP_SLVERR;
      end else if (araddr == gpt_pkg::OFF_IRQ_STAT) begin
        rdata_d[NUM_TIMERS-1:0] = stat_q;
      end else if (araddr == gpt_pkg::OFF_IRQ_MASK) begin
        rdata_d[NUM_TIMERS-1:0] = mask_q;
      end else if (araddr == gpt_pkg::OFF_UNIT_INT) begin
        rdata_d[7:0] = uint_q;
      end else if (araddr == gpt_pkg::OFF_UNIT_FRAC) begin
        rdata_d[7:0] = ufrac_q;
      end else if (k < NUM_TIMERS && araddr[3:0] == gpt_pkg::OFF_CTRL) begin
        rdata_d[3:0] = ctrl_q[k];
      end else if (k < NUM_TIMERS && araddr[3:0] == gpt_pkg::OFF_LOAD) begin
        rdata_d = load_q[k];
      end else if (k < NUM_TIMERS && araddr[3:0] == gpt_pkg::OFF_COUNT) begin
        rdata_d = count[k];
      end else begin
        rresp_d = gpt_pkg::RESP_SLVERR;
      end
    end
    if (rvalid && rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // microsecond enable from integer plus fractional divisor
  always_comb begin
    logic [8:0] sum;
    logic [8:0] target;
    sum     = {1'b0, acc_q} + {1'b0, ufrac_q};
    // an integer part of zero still gives one clock per unit
    target  = {1'b0, (uint_q == 8'h00) ? 8'h01 : uint_q} + {8'h00, extra_q};
    div_d   = div_q + 8'h01;
    acc_d   = acc_q;
    extra_d = extra_q;
    tick_d  = 1'b0;
    if ({1'b0, div_q} + 9'h001 >= target) begin
      // carry out of the fraction lengthens the next unit by one clock
      div_d   = 8'h00;
      acc_d   = sum[7:0];
      extra_d = sum[8];
      tick_d  = 1'b1;
    end
  end

  // interrupt level from unmasked sticky flags
  always_comb begin
    irq_d = |(stat_d & mask_d);
  end

  ////////////////////////////////////////////////////////////////////////
  // all registers of the block except those inside the timer channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      waddr_q  <= 8'h00;
      wdat_q   <= 32'h0000_0000;
      wbe_q    <= 4'h0;
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= gpt_pkg::RESP_OKAY;
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= 32'h0000_0000;
      rresp    <= gpt_pkg::RESP_OKAY;
      stat_q   <= '0;
      mask_q   <= gpt_pkg::MASK_RST[NUM_TIMERS-1:0];
      uint_q   <= gpt_pkg::UNIT_INT_RST;
      ufrac_q  <= gpt_pkg::UNIT_FRAC_RST;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        ctrl_q[i] <= 4'h0;
        load_q[i] <= gpt_pkg::LOAD_RST;
      end
      div_q    <= 8'h00;
      acc_q    <= 8'h00;
      extra_q  <= 1'b0;
      tick_q   <= 1'b0;
      irq      <= 1'b0;
      es1_q    <= '0;
      es2_q    <= '0;
      es3_q    <= '0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q  <= w_got_d;
      waddr_q  <= waddr_d;
      wdat_q   <= wdat_d;
      wbe_q    <= wbe_d;
      awready  <= awready_d;
      wready   <= wready_d;
      bvalid   <= bvalid_d;
      bresp    <= bresp_d;
      arready  <= arready_d;
      rvalid   <= rvalid_d;
      rdata    <= rdata_d;
      rresp    <= rresp_d;
      stat_q   <= stat_d;
      mask_q   <= mask_d;
      uint_q   <= uint_d;
      ufrac_q  <= ufrac_d;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        ctrl_q[i] <= ctrl_d[i];
        load_q[i] <= load_d[i];
      end
      div_q    <= div_d;
      acc_q    <= acc_d;
      extra_q  <= extra_d;
      tick_q   <= tick_d;
      irq      <= irq_d;
      // pins pass two flops before the edge detector looks at them
      es1_q    <= evt_in;
      es2_q    <= es1_q;
      es3_q    <= es2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timer channels, each fully independent
  for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
    gpt_channel u_chan (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .enable     (ctrl_q[g][gpt_pkg::CTRL_EN_BIT]),
      .periodic   (ctrl_q[g][gpt_pkg::CTRL_PERIODIC_BIT]),
      .timer_mode (ctrl_q[g][gpt_pkg::CTRL_TIMER_BIT]),
      .coarse     (ctrl_q[g][gpt_pkg::CTRL_COARSE_BIT]),
      .load_val   (load_q[g]),
      .us_tick    (tick_q),
      .evt_tick   (es2_q[g] && !es3_q[g]),
      .count_q    (count[g]),
      .timeout_q  (tmo[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // irq is registered from the same next values as the flags, so it tracks them in the same cycle
  irq_follow_a : assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(stat_q & mask_q)) else $error("irq does not follow unmasked flags");
  flag_sticky_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (stat_q[0] && !(wr_en && waddr_q == gpt_pkg::OFF_IRQ_STAT)) |=> stat_q[0])
    else $error("timeout flag dropped without clear");
  flag_set_a : assert property (@(posedge aclk) disable iff (!aresetn)
    tmo[0] |=> stat_q[0]) else $error("timeout did not set flag");
  oneshot_stop_a : assert property (@(posedge aclk) disable iff (!aresetn)
    tmo[0] && !ctrl_q[0][gpt_pkg::CTRL_PERIODIC_BIT] && !wr_en
    |=> !ctrl_q[0][gpt_pkg::CTRL_EN_BIT]) else $error("one-shot did not stop");
  periodic_run_a : assert property (@(posedge aclk) disable iff (!aresetn)
    tmo[0] && ctrl_q[0][gpt_pkg::CTRL_PERIODIC_BIT] && !wr_en
    |=> ctrl_q[0][gpt_pkg::CTRL_EN_BIT]) else $error("periodic timer stopped");
  // a write to either divisor register retimes the divider, so it abandons the check
  unit_period_a : assert property (@(posedge aclk)
    disable iff (!aresetn || (wr_en && waddr_q[7:4] == 4'h0 && waddr_q[3]))
    tick_q && ufrac_q == 8'h00 && uint_q == 8'h0A && !extra_q && !wr_en
    |=> !tick_q [*8] ##1 !tick_q ##1 tick_q) else $error("us enable period wrong");
endmodule
`default_nettype wire

// ===== sim/gpt_top_test.sv
// self-checking bench for the quad timer block, driven over its axi4-lite port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module gpt_top_test;
  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic        aclk    = 1'b0;  // 10 MHz bus clock
  logic        aresetn = 1'b0;  // synchronous, active low
  logic        awvalid = 1'b0;  // write address channel
  logic [7:0]  awaddr  = 8'h00;
  logic        wvalid  = 1'b0;  // write data channel
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  wstrb   = 4'hF;  // whole words only
  logic        bready  = 1'b1;  // held high: always willing to take a response
  logic        arvalid = 1'b0;  // read address channel
  logic [7:0]  araddr  = 8'h00;
  logic        rready  = 1'b1;  // held high, same reasoning as bready
  logic [3:0]  evt_in  = 4'h0;  // event pins for counter mode
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          failures = 0;    // mismatches
  int          n_checks = 0;    // comparisons made
  logic [31:0] d0, d1;          // scratch read values
  logic [1:0]  rs;              // scratch response
  int          n;               // measured latency in cycles

  always #50 aclk = ~aclk;

  gpt_top #(.NUM_TIMERS(4)) gpt_top_inst (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .evt_in(evt_in), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus tasks: entered just after a rising edge, release only on handshake
  function automatic logic [7:0] ta(input int i, input logic [3:0] off);
    ta = gpt_pkg::OFF_TMR_BASE + 8'(i) * gpt_pkg::TMR_STRIDE + {4'h0, off};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    bit aw_ok, w_ok, b_ok;
    aw_ok = 0; w_ok = 0; b_ok = 0; resp = 2'h3;
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d;
    // no local limit: only the watchdog ends a wait for the slave
    while (!b_ok) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin aw_ok = 1; awvalid <= 1'b0; end
      if (!w_ok && wready === 1'b1) begin w_ok = 1; wvalid <= 1'b0; end
      if (aw_ok && w_ok && bvalid === 1'b1) begin b_ok = 1; resp = bresp; end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    bit ar_ok, r_ok;
    ar_ok = 0; r_ok = 0; d = 32'hDEAD_BEEF; resp = 2'h3;
    arvalid <= 1'b1; araddr <= a;
    while (!r_ok) begin
      @(posedge aclk);
      if (!ar_ok && arready === 1'b1) begin ar_ok = 1; arvalid <= 1'b0; end
      else if (ar_ok && rvalid === 1'b1) begin r_ok = 1; d = rdata; resp = rresp; end
    end
  endtask

  // short write whose response must be okay
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    `CHK("wresp", gpt_pkg::RESP_OKAY, r)
  endtask

  // read and compare data and response
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(nm, e, d)
    `CHK(nm, er, r)
  endtask

  // cycles until irq is seen high, bounded by lim
  task automatic wait_irq(input int lim, output int cnt);
    cnt = 0;
    while (irq !== 1'b1 && cnt < lim) begin @(posedge aclk); cnt++; end
  endtask

  task automatic pulse(input int i);
    evt_in[i] <= 1'b1; repeat (3) @(posedge aclk);
    evt_in[i] <= 1'b0; repeat (3) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // closing: one place for the verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 8000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values, 32-bit load, refused accesses
    rc("unit_int", gpt_pkg::OFF_UNIT_INT, 32'h0000_000A, 2'h0);
    rc("unit_frac", gpt_pkg::OFF_UNIT_FRAC, 32'h0, 2'h0);
    rc("status", gpt_pkg::OFF_IRQ_STAT, 32'h0, 2'h0);
    for (int i = 0; i < 4; i++) rc("ctrl", ta(i, gpt_pkg::OFF_CTRL), 32'h0, 2'h0);
    w(ta(3, gpt_pkg::OFF_LOAD), 32'hFFFF_FFFF);
    rc("load32", ta(3, gpt_pkg::OFF_LOAD), 32'hFFFF_FFFF, 2'h0);
    wr(ta(0, gpt_pkg::OFF_COUNT), 32'h0000_0055, rs);
    `CHK("count_wr", gpt_pkg::RESP_SLVERR, rs)
    rc("count_ro", ta(0, gpt_pkg::OFF_COUNT), 32'h0, 2'h0);
    rc("idx4", ta(4, gpt_pkg::OFF_CTRL), 32'h0, gpt_pkg::RESP_SLVERR);
    rc("misalign", 8'h02, 32'h0, gpt_pkg::RESP_SLVERR);
    $display("test registers done");
    // one timer runs and stops alone; timer 0 stays still
    w(ta(3, gpt_pkg::OFF_CTRL), 32'h5);
    rd(ta(3, gpt_pkg::OFF_COUNT), d0, rs);
    repeat (40) @(posedge aclk);
    rd(ta(3, gpt_pkg::OFF_COUNT), d1, rs);
    `CHK("runs", 1'b1, d1 < d0)
    w(ta(3, gpt_pkg::OFF_CTRL), 32'h4);
    rd(ta(3, gpt_pkg::OFF_COUNT), d0, rs);
    repeat (40) @(posedge aclk);
    rc("holds", ta(3, gpt_pkg::OFF_COUNT), d0, 2'h0);
    rc("other", ta(0, gpt_pkg::OFF_COUNT), 32'h0, 2'h0);
    $display("test independence done");
    // fine one-shot: five units of ten clocks, then enable cleared
    w(gpt_pkg::OFF_IRQ_MASK, 32'hF);
    w(ta(0, gpt_pkg::OFF_LOAD), 32'h5);
    w(ta(0, gpt_pkg::OFF_CTRL), 32'h5);
    wait_irq(200, n);
    `CHK("fine_lat", 1'b1, n >= 42 && n <= 56)
    rc("oneshot_ctrl", ta(0, gpt_pkg::OFF_CTRL), 32'h4, 2'h0);
    rc("oneshot_cnt", ta(0, gpt_pkg::OFF_COUNT), 32'h0, 2'h0);
    rc("sticky", gpt_pkg::OFF_IRQ_STAT, 32'h1, 2'h0);
    w(gpt_pkg::OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK("irq_clr", 1'b0, irq)
    $display("test oneshot done");
    // masked timeout: flag set, no interrupt until unmasked
    w(gpt_pkg::OFF_IRQ_MASK, 32'hE);
    w(ta(0, gpt_pkg::OFF_CTRL), 32'h5);
    repeat (80) @(posedge aclk);
    `CHK("masked", 1'b0, irq)
    rc("masked_st", gpt_pkg::OFF_IRQ_STAT, 32'h1, 2'h0);
    w(gpt_pkg::OFF_IRQ_MASK, 32'hF);
    repeat (2) @(posedge aclk);
    `CHK("unmasked", 1'b1, irq)
    w(gpt_pkg::OFF_IRQ_STAT, 32'h1);
    $display("test mask done");
    // periodic: reloads and times out again without software
    // timer 0 again, so the periodic checks inside the design see a timeout too
    w(ta(0, gpt_pkg::OFF_LOAD), 32'h3);
    w(ta(0, gpt_pkg::OFF_CTRL), 32'h7);
    wait_irq(100, n);
    w(gpt_pkg::OFF_IRQ_STAT, 32'h1);
    wait_irq(100, n);
    `CHK("reload", 1'b1, n >= 18 && n <= 30)
    rc("per_ctrl", ta(0, gpt_pkg::OFF_CTRL), 32'h7, 2'h0);
    w(ta(0, gpt_pkg::OFF_CTRL), 32'h6);
    w(gpt_pkg::OFF_IRQ_STAT, 32'h1);
    $display("test periodic done");
    // coarse: one unit is 256 fine units
    w(ta(2, gpt_pkg::OFF_LOAD), 32'h1);
    w(ta(2, gpt_pkg::OFF_CTRL), 32'hD);
    wait_irq(3000, n);
    `CHK("coarse_lat", 1'b1, n >= 2545 && n <= 2570)
    w(gpt_pkg::OFF_IRQ_STAT, 32'h4);
    $display("test coarse done");
    // fractional divisor: 4.5 clocks per unit, twenty units
    w(gpt_pkg::OFF_UNIT_INT, 32'h4);
    w(gpt_pkg::OFF_UNIT_FRAC, 32'h80);
    w(ta(0, gpt_pkg::OFF_LOAD), 32'h14);
    w(ta(0, gpt_pkg::OFF_CTRL), 32'h5);
    wait_irq(300, n);
    `CHK("frac_lat", 1'b1, n >= 84 && n <= 98)
    w(gpt_pkg::OFF_IRQ_STAT, 32'h1);
    $display("test fraction done");
    // counter mode: three event edges make the timeout
    w(ta(2, gpt_pkg::OFF_LOAD), 32'h3);
    w(ta(2, gpt_pkg::OFF_CTRL), 32'h1);
    pulse(2);
    pulse(2);
    repeat (8) @(posedge aclk);
    `CHK("evt_early", 1'b0, irq)
    evt_in[2] <= 1'b1;
    wait_irq(20, n);
    `CHK("evt_lat", 1'b1, n >= 3 && n <= 8)
    evt_in[2] <= 1'b0;
    $display("test counter done");
    final_report();
  end
endmodule
`default_nettype wire
